// ### src/pll_div_cfg.svh
// constants of the pll prescaler and system clock dividers
//
// What this block does
// [RQ1] prescaler ratio in bits 4:0 divides by value plus one, resets to zero
// [RQ2] prescaler register bit 15 enables the prescaler, resets to one
// [RQ3] divider register bits 14:5 read zero, writes to them are ignored
// [RQ4] system clock one comes from its own divider on bypass and pll paths
// [RQ5] first divider register bit 15 enables that divider, resets to one
// [RQ6] first divider codes 00000, 00001, 00011 give divide 1, 2, 4; resets 00011
// [RQ7] software never writes code 00010 or 00100 upward to the first divider
// [RQ8] system clock two comes from its own divider on bypass and pll paths
// [RQ9] second divider register bit 15 enables that divider, resets to one
// [RQ10] second divider codes 00000, 00001, 00011 give divide 1, 2, 4; resets 00011
// [RQ11] software never writes code 00010 or 00100 upward to the second divider
// [RQ12] path select clear divides the reference, set divides the pll output
// [RQ13] locked pll output follows multiplier and prescaled reference clock
// [RQ14] disabled divider holds output low; ratio changes only at period boundary
`ifndef PLL_DIV_CFG_SVH
`define PLL_DIV_CFG_SVH

// register offsets
`define PRESCALER_CTRL_OFS 16'h1c8a
`define SYSCLK_ONE_CTRL_OFS 16'h1c8c
`define SYSCLK_TWO_CTRL_OFS 16'h1c8e
`define DIVIDER_STATUS_OFS 16'h1c94
`define PLL_PATH_CTRL_OFS 16'h1c96

// field positions
`define DIV_ENABLE_BIT 15
`define DIV_RATIO_MSB 4
`define PATH_SELECT_BIT 0
`define MULT_MSB 12
`define MULT_LSB 8
`define STAT_LOCKED_BIT 15
`define STAT_PATH_BIT 14

// reset values
`define PRESCALER_RATIO_RST 5'h00
`define SYSCLK_RATIO_RST 5'h03
`define DIV_ENABLE_RST 1'b1
`define PATH_SELECT_RST 1'b0
`define MULT_RST 5'h00

// ratio codes of the system clock dividers
`define SYSCLK_CODE_DIV1 5'h00
`define SYSCLK_CODE_DIV2 5'h01
`define SYSCLK_CODE_DIV4 5'h03

`endif

// ### src/pll_div_pkg.sv
// types and ratio decoding shared by the divider modules
package pll_div_pkg;
   typedef logic [4:0] ratio_t;
   typedef logic [15:0] word_t;

   // prescaler: count limit is the code itself, period is code plus one
   function automatic ratio_t prescaler_limit(input ratio_t code);
      return code;
   endfunction : prescaler_limit

   // system dividers: reserved codes fall back to divide by four
   function automatic ratio_t sysclk_limit(input ratio_t code);
      ratio_t lim;
      lim = 5'h03;
      if (code == 5'h00)
      begin
         lim = 5'h00;
      end
      else if (code == 5'h01)
      begin
         lim = 5'h01;
      end
      return lim;
   endfunction : sysclk_limit
endpackage : pll_div_pkg

// ### src/div_ctrl_if.sv
// control and output signals between the top and one divider
`timescale 1ns/1ns
interface div_ctrl_if;
   logic enable;
   pll_div_pkg::ratio_t limit;
   logic src_tick;
   logic out_tick;
   pll_div_pkg::ratio_t active_limit;

   modport ctrl
   (
      output enable,
      output limit,
      output src_tick,
      input out_tick,
      input active_limit
   );
   modport div
   (
      input enable,
      input limit,
      input src_tick,
      output out_tick,
      output active_limit
   );
endinterface : div_ctrl_if

// ### src/tick_divider.sv
// one programmable divider of a tick stream
`timescale 1ns/1ns
module tick_divider
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   div_ctrl_if.div dv
);
   import pll_div_pkg::*;

   ratio_t cnt_q;
   ratio_t lim_q;
   logic out_q;
   // a period that has not counted yet takes the newest limit, so the first
   // period after reset or enable already has the programmed length
   wire fresh = (cnt_q == 5'h00);
   wire [4:0] cur_lim = fresh ? dv.limit : lim_q;
   wire hit = (cnt_q == cur_lim);
   wire step = dv.src_tick && dv.enable;

   // count source ticks; a new limit is taken only on wrap or while stopped
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= 5'h00;
         lim_q <= 5'h00;
         out_q <= 1'b0;
      end
      else if (clk_en)
      begin
         out_q <= step && hit; // [RQ14]
         if (!dv.enable)
         begin
            cnt_q <= 5'h00; // [RQ14]
            lim_q <= dv.limit;
         end
         else if (step && hit)
         begin
            cnt_q <= 5'h00;
            lim_q <= cur_lim; // [RQ14]
         end
         else if (step)
         begin
            cnt_q <= cnt_q + 5'h01;
            lim_q <= cur_lim; // [RQ14]
         end
      end
   end

   assign dv.out_tick = out_q;
   assign dv.active_limit = lim_q;
endmodule : tick_divider

// ### src/pll_clock_dividers.sv
// prescaler and system clock one and two dividers with their registers
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "pll_div_cfg.svh"
module pll_clock_dividers
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [15:0] reg_addr,
   input wire pll_div_pkg::word_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output pll_div_pkg::word_t reg_rdata,
   input wire logic ref_clk_tick,
   input wire logic pll_out_tick,
   input wire logic pll_locked,
   output logic prescaler_clock,
   output pll_div_pkg::ratio_t pll_multiplier,
   output logic pll_path_select,
   output logic system_clock_one,
   output logic system_clock_two
);
   import pll_div_pkg::*;

   // register state
   logic prescaler_enable_q;
   ratio_t prescaler_ratio_q;
   logic sysclk_one_div_enable_q;
   ratio_t sysclk_one_div_ratio_q;
   logic sysclk_two_div_enable_q;
   ratio_t sysclk_two_div_ratio_q;
   logic path_select_q;
   ratio_t multiplier_q;
   word_t rdata_q;
   word_t rdata_d;

   // address decode, one wire per register
   wire hit_pre = (reg_addr == `PRESCALER_CTRL_OFS);
   wire hit_one = (reg_addr == `SYSCLK_ONE_CTRL_OFS);
   wire hit_two = (reg_addr == `SYSCLK_TWO_CTRL_OFS);
   wire hit_stat = (reg_addr == `DIVIDER_STATUS_OFS);
   wire hit_path = (reg_addr == `PLL_PATH_CTRL_OFS);

   // write strobes per register
   wire wr_pre = reg_wr && hit_pre;
   wire wr_one = reg_wr && hit_one;
   wire wr_two = reg_wr && hit_two;
   wire wr_path = reg_wr && hit_path;

   // only the enable, ratio, path select and multiplier fields of a write are kept
   wire wr_enable = reg_wdata[`DIV_ENABLE_BIT]; // [RQ3]
   wire [4:0] wr_ratio = reg_wdata[`DIV_RATIO_MSB:0]; // [RQ3]
   wire wr_path_sel = reg_wdata[`PATH_SELECT_BIT];
   wire [4:0] wr_mult = reg_wdata[`MULT_MSB:`MULT_LSB];

   // prescaler register
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prescaler_enable_q <= `DIV_ENABLE_RST; // [RQ2]
         prescaler_ratio_q <= `PRESCALER_RATIO_RST; // [RQ1]
      end
      else if (clk_en && wr_pre)
      begin
         prescaler_enable_q <= wr_enable; // [RQ2]
         prescaler_ratio_q <= wr_ratio; // [RQ1]
      end
   end

   // first system clock divider register
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sysclk_one_div_enable_q <= `DIV_ENABLE_RST; // [RQ5]
         sysclk_one_div_ratio_q <= `SYSCLK_RATIO_RST; // [RQ6]
      end
      else if (clk_en && wr_one)
      begin
         sysclk_one_div_enable_q <= wr_enable; // [RQ5]
         sysclk_one_div_ratio_q <= wr_ratio; // [RQ6]
      end
   end

   // second system clock divider register
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sysclk_two_div_enable_q <= `DIV_ENABLE_RST; // [RQ9]
         sysclk_two_div_ratio_q <= `SYSCLK_RATIO_RST; // [RQ10]
      end
      else if (clk_en && wr_two)
      begin
         sysclk_two_div_enable_q <= wr_enable; // [RQ9]
         sysclk_two_div_ratio_q <= wr_ratio; // [RQ10]
      end
   end

   // path select and multiplier setting handed to the pll
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         path_select_q <= `PATH_SELECT_RST;
         multiplier_q <= `MULT_RST;
      end
      else if (clk_en && wr_path)
      begin
         path_select_q <= wr_path_sel; // [RQ12]
         multiplier_q <= wr_mult; // [RQ13]
      end
   end

   // read-back words; reserved bits 14:5 are tied to zero
   wire [9:0] rsvd_zero = 10'h000; // [RQ3]
   wire [15:0] pre_word = {prescaler_enable_q, rsvd_zero, prescaler_ratio_q};
   wire [15:0] one_word = {sysclk_one_div_enable_q, rsvd_zero, sysclk_one_div_ratio_q};
   wire [15:0] two_word = {sysclk_two_div_enable_q, rsvd_zero, sysclk_two_div_ratio_q};
   wire [15:0] path_word = {3'h0, multiplier_q, 7'h00, path_select_q};

   // the dividers, each fed by its own interface
   div_ctrl_if pre_if ();
   div_ctrl_if one_if ();
   div_ctrl_if two_if ();

   // status shows the lock input, the path and the limits now in effect in both system dividers
   wire [15:0] stat_word = {pll_locked, path_select_q, 4'h0,
                            two_if.active_limit, one_if.active_limit};

   // read multiplexer; unmapped offsets read as zero
   always_comb
   begin
      rdata_d = 16'h0000;
      if (hit_pre)
      begin
         rdata_d = pre_word;
      end
      else if (hit_one)
      begin
         rdata_d = one_word;
      end
      else if (hit_two)
      begin
         rdata_d = two_word;
      end
      else if (hit_stat)
      begin
         rdata_d = stat_word;
      end
      else if (hit_path)
      begin
         rdata_d = path_word;
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_q <= 16'h0000;
      end
      else if (clk_en)
      begin
         rdata_q <= reg_rd ? rdata_d : 16'h0000;
      end
   end

   // prescaler works on the raw reference ticks
   assign pre_if.enable = prescaler_enable_q; // [RQ2]
   assign pre_if.limit = prescaler_limit(prescaler_ratio_q); // [RQ1]
   assign pre_if.src_tick = ref_clk_tick;

   // both system dividers take the same selected source, each with its own counter, enable and ratio
   wire sys_src_tick = path_select_q ? pll_out_tick : ref_clk_tick; // [RQ12]

   assign one_if.enable = sysclk_one_div_enable_q; // [RQ5]
   assign one_if.limit = sysclk_limit(sysclk_one_div_ratio_q); // [RQ6]
   assign one_if.src_tick = sys_src_tick; // [RQ4]

   assign two_if.enable = sysclk_two_div_enable_q; // [RQ9]
   assign two_if.limit = sysclk_limit(sysclk_two_div_ratio_q); // [RQ10]
   assign two_if.src_tick = sys_src_tick; // [RQ8]

   tick_divider u_prescaler
   (
      .clock(clock),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .dv(pre_if.div)
   );

   tick_divider u_first_output_divider
   (
      .clock(clock),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .dv(one_if.div)
   );

   tick_divider u_second_output_divider
   (
      .clock(clock),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .dv(two_if.div)
   );

   // outputs; the prescaled reference and multiplier set the pll rate
   assign reg_rdata = rdata_q;
   assign prescaler_clock = pre_if.out_tick; // [RQ13]
   assign pll_multiplier = multiplier_q; // [RQ13]
   assign pll_path_select = path_select_q;
   assign system_clock_one = one_if.out_tick; // [RQ4]
   assign system_clock_two = two_if.out_tick; // [RQ8]
endmodule : pll_clock_dividers

// ### testbench/pll_clock_dividers_monitor.sv
// checker of the divider block at its ports
`timescale 1ns/1ns
module pll_clock_dividers_monitor
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [15:0] reg_addr,
   input wire pll_div_pkg::word_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire pll_div_pkg::word_t reg_rdata,
   input wire logic ref_clk_tick,
   input wire logic pll_out_tick,
   input wire logic pll_locked,
   input wire logic prescaler_clock,
   input wire pll_div_pkg::ratio_t pll_multiplier,
   input wire logic pll_path_select,
   input wire logic system_clock_one,
   input wire logic system_clock_two
);
   import pll_div_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // tick feeding the system dividers, as the path select picks it
   wire src = pll_path_select ? pll_out_tick : ref_clk_tick;
   sequence s_wr(a);
      reg_wr && clk_en && reg_addr == a;
   endsequence
   sequence s_rd(a);
      reg_rd && clk_en && reg_addr == a;
   endsequence
   a_rsv_reads_zero: assert property (
      s_rd(16'h1c8a) or s_rd(16'h1c8c) or s_rd(16'h1c8e) |=> reg_rdata[14:5] == 10'h000)
      else $error("reserved bits nonzero");
   a_pre_off_quiet: assert property (
      s_wr(16'h1c8a) ##0 !reg_wdata[15] |=> ##1 !prescaler_clock)
      else $error("prescaler runs while off");
   a_one_off_quiet: assert property (
      s_wr(16'h1c8c) ##0 !reg_wdata[15] |=> ##1 !system_clock_one)
      else $error("sysclk one runs while off");
   a_two_off_quiet: assert property (
      s_wr(16'h1c8e) ##0 !reg_wdata[15] |=> ##1 !system_clock_two)
      else $error("sysclk two runs while off");
   // a pulse may only follow a source tick; frozen cycles are excused
   a_pre_from_ref: assert property (
      prescaler_clock && $past(clk_en) |-> $past(ref_clk_tick))
      else $error("prescaler pulse without tick");
   a_one_from_src: assert property (
      system_clock_one && $past(clk_en) |-> $past(src))
      else $error("sysclk one pulse without tick");
   a_two_from_src: assert property (
      system_clock_two && $past(clk_en) |-> $past(src))
      else $error("sysclk two pulse without tick");
   a_path_written: assert property (
      s_wr(16'h1c96) |=> pll_path_select == $past(reg_wdata[0])
         && pll_multiplier == $past(reg_wdata[12:8]))
      else $error("path control not applied");
endmodule : pll_clock_dividers_monitor

bind pll_clock_dividers pll_clock_dividers_monitor mon
(
   .clock, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .ref_clk_tick, .pll_out_tick, .pll_locked, .prescaler_clock, .pll_multiplier,
   .pll_path_select, .system_clock_one, .system_clock_two
);

// ### testbench/pll_clock_dividers_bench.sv
// self-checking bench of the prescaler and system clock dividers
`timescale 1ns/1ns
`define CHK(nm, e, g) \
   begin \
      total_checks++; \
      if ((g) !== (e)) \
      begin \
         mismatches++; \
         $display("[ERR] %s expected %h seen %h", nm, e, g); \
      end \
   end
module pll_clock_dividers_bench;
   import pll_div_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   word_t reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   word_t reg_rdata;
   logic ref_clk_tick = 1'b1;
   logic pll_out_tick = 1'b0;
   logic pll_locked = 1'b0;
   logic prescaler_clock;
   ratio_t pll_multiplier;
   logic pll_path_select;
   logic system_clock_one;
   logic system_clock_two;
   int total_checks = 0;
   int mismatches = 0;
   // four-state counters, so an unknown pulse level cannot pass as zero
   integer n0;
   integer n1;
   integer n2;
   int codes[3] = '{0, 1, 3};
   int pres[3] = '{0, 2, 31};
   always #20 clock = ~clock;
   pll_clock_dividers uut
   (
      .clock, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .ref_clk_tick, .pll_out_tick, .pll_locked, .prescaler_clock, .pll_multiplier,
      .pll_path_select, .system_clock_one, .system_clock_two
   );
   task automatic wr(input logic [15:0] a, input word_t d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [15:0] a, input word_t e);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      `CHK("rdata", e, reg_rdata)
   endtask : rd
   // counts pulses at mid-cycle, where the outputs have settled
   task automatic cnt(input int n);
      n0 = 0;
      n1 = 0;
      n2 = 0;
      repeat (n)
      begin
         @(negedge clock);
         n0 += prescaler_clock;
         n1 += system_clock_one;
         n2 += system_clock_two;
      end
   endtask : cnt
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   initial
   begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      rd(16'h1c8a, 16'h8000);
      rd(16'h1c8c, 16'h8003);
      rd(16'h1c8e, 16'h8003);
      rd(16'h1c80, 16'h0000);
      cnt(32);
      `CHK("pre", 32, n0)
      `CHK("one", 8, n1)
      `CHK("two", 8, n2)
      wr(16'h1c8c, 16'h7fe1);
      rd(16'h1c8c, 16'h0001);
      wr(16'h1c8a, 16'h7fe2);
      rd(16'h1c8a, 16'h0002);
      cnt(32);
      `CHK("pre off", 0, n0)
      `CHK("one off", 0, n1)
      `CHK("two on", 8, n2)
      wr(16'h1c8e, 16'h0003);
      // a pulse launched at the write edge still stands for one cycle
      @(posedge clock);
      cnt(8);
      `CHK("two off", 0, n2)
      // ratio changes wait for a period end, so let the old one finish
      foreach (codes[i])
      begin
         wr(16'h1c8c, 16'h8000 | 16'(codes[i]));
         wr(16'h1c8e, 16'h8000 | 16'(codes[i]));
         repeat (8) @(posedge clock);
         cnt(32);
         `CHK("one ratio", 32 / (codes[i] + 1), n1)
         `CHK("two ratio", 32 / (codes[i] + 1), n2)
      end
      foreach (pres[i])
      begin
         wr(16'h1c8a, 16'h8000 | 16'(pres[i]));
         repeat (40) @(posedge clock);
         cnt(96);
         `CHK("pre ratio", 96 / (pres[i] + 1), n0)
      end
      // without reference ticks nothing divides
      ref_clk_tick <= 1'b0;
      cnt(32);
      `CHK("no ref", 0, n0 + n1 + n2)
      ref_clk_tick <= 1'b1;
      // pll path with a silent pll, then a running one
      wr(16'h1c96, 16'h0501);
      rd(16'h1c96, 16'h0501);
      `CHK("mult", 5'h05, pll_multiplier)
      cnt(32);
      `CHK("pll idle", 0, n1 + n2)
      @(posedge clock);
      pll_out_tick <= 1'b1;
      pll_locked <= 1'b1;
      // count only cycles that all carry a pll tick
      @(posedge clock);
      cnt(32);
      `CHK("pll run", 16, n1 + n2)
      rd(16'h1c94, 16'hc063);
      // a frozen block ignores strobes and keeps its registers
      clk_en <= 1'b0;
      wr(16'h1c96, 16'h0000);
      @(negedge clock);
      `CHK("frozen path", 1'b1, pll_path_select)
      clk_en <= 1'b1;
      rd(16'h1c96, 16'h0501);
      summarize();
   end
endmodule : pll_clock_dividers_bench
